//--- rtl/deinterlace_history_sequencer.sv
// How it works
// - Enabled output is always progressive frames
// - Own blanking strobes wrap output pixels
// - Accepts 4:2:0, 4:2:2 and 4:4:4
// - Format fixed by parameter or software
// - Motion kernel needs two history fields
// - Without history keep progressive, no motion
// - First two frames are field interpolated
// - Input change resets memory, interpolates
// - Motion returns after two rebuilt frames
// - Video, register and memory clock domains
// - Video domain cleared by active-high reset
// - Register, memory resets separate, active low
// - Clocks may be fully asynchronous
// - Register, memory, stream bus roles
// - Input blanking only locates frame start and line end
`timescale 1ns/1ps

module deinterlace_history_sequencer #(
  parameter logic FMT_DYNAMIC = 1'b1,
  parameter deint_pkg::chroma_fmt_t FMT_STATIC = deint_pkg::FMT_422,
  parameter int LINE_MAX = 2048
) (
  input wire logic clk,
  input wire logic reset,
  input wire deint_pkg::vid_in_t vid_in,
  input wire logic vid_in_valid,
  output logic vid_ce,
  input wire logic cfg_clk,
  input wire logic cfg_reset_n,
  input wire deint_pkg::cfg_t general_processor_config_port,
  input wire logic mem_clk,
  input wire logic mem_reset_n,
  input wire logic mem_history_ok,
  output logic mem_if_reset,
  output deint_pkg::vid_out_t vid_out,
  output logic vid_out_valid,
  input wire logic vid_out_ready,
  output logic motion_active,
  output logic frame_error
);

  // ****************************************************
  // Declarations
  // ****************************************************
  localparam int XW = $clog2(LINE_MAX) + 1;
  localparam int CW = $bits(deint_pkg::cfg_t);

  typedef enum {EM_IDLE, EM_VBLANK, EM_PIXELS, EM_HBLANK} emit_state_t;

  // Line store, two banks
  logic [deint_pkg::PIX_W-1:0] line_mem [2][LINE_MAX];
  // Configuration held in the register domain
  deint_pkg::cfg_t cfg_q;
  // Configuration after crossing into video domain
  logic [CW-1:0] cfg_sync;
  // Crossed word, offset so cleared stages mean the reset word
  logic [CW-1:0] cfg_diff_sync;
  deint_pkg::cfg_t cfg_prev_q;
  deint_pkg::cfg_t cfg_live_q;
  deint_pkg::chroma_fmt_t fmt;
  // Clock-enable strobe to the source
  logic vid_ce_q;
  // Input framing
  logic act_pix;
  logic line_act_q;
  logic vblank_seen_q;
  logic line_end;
  logic new_frame;
  logic [XW-1:0] wr_x_q;
  logic wr_bank_q;
  logic [XW-1:0] last_w_q;
  logic last_w_vld_q;
  // Restart events
  logic change;
  logic overrun;
  logic restart;
  logic err_q;
  // History tracking
  logic [1:0] hist_q;
  logic armed_q;
  logic motion_q;
  logic mem_ok;
  // Memory reset request, toggles per restart
  logic restart_tgl_q;
  logic mem_tgl_sync;
  logic mem_tgl_prev_q;
  logic [2:0] mem_rst_cnt_q;
  logic mem_ok_q;
  logic mem_if_reset_q;
  // Emitter
  emit_state_t em_q;
  logic [XW-1:0] rd_x_q;
  logic [XW-1:0] rd_len_q;
  logic rd_bank_q;
  logic [1:0] pass_q;
  logic [1:0] passes_q;
  logic first_line_q;
  logic em_fmotion_q;
  deint_pkg::chroma_fmt_t em_fmt_q;
  logic em_valid;
  logic em_ready;
  deint_pkg::vid_out_t em_data;

  // ****************************************************
  // Register domain
  // ****************************************************
  // Capture the processor port under its own reset
  // register clock domain
  always_ff @(posedge cfg_clk) begin
    if (!cfg_reset_n) begin
      cfg_q <= deint_pkg::CFG_RESET;
    end else begin
      cfg_q <= general_processor_config_port;
    end
  end

  level_sync #(.W(CW)) u_cfg_sync (
    .clk(clk),
    .reset(reset),
    .d(cfg_q ^ deint_pkg::CFG_RESET),
    .q(cfg_diff_sync)
  );

  // Synchroniser clears to zero; undo the offset so a cleared
  // stage reads as the reset word and no false change follows reset
  assign cfg_sync = cfg_diff_sync ^ deint_pkg::CFG_RESET;

  // Take the word only once two samples agree
  // skew tolerant
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_prev_q <= deint_pkg::CFG_RESET;
      cfg_live_q <= deint_pkg::CFG_RESET;
    end else begin
      cfg_prev_q <= deint_pkg::cfg_t'(cfg_sync);
      if (deint_pkg::cfg_t'(cfg_sync) == cfg_prev_q) begin
        cfg_live_q <= cfg_prev_q;
      end
    end
  end

  assign fmt = FMT_DYNAMIC ? cfg_live_q.fmt : FMT_STATIC;

  // ****************************************************
  // Input framing
  // ****************************************************
  // Half-rate strobe that throttles the source
  // synchronous clear
  always_ff @(posedge clk) begin
    if (reset) begin
      vid_ce_q <= 1'b0;
    end else begin
      vid_ce_q <= !vid_ce_q;
    end
  end

  assign act_pix = vid_in_valid && vid_ce_q && !vid_in.hblank
                   && !vid_in.vblank;
  assign line_end = line_act_q && vid_in_valid && vid_ce_q
                    && vid_in.hblank;
  assign new_frame = act_pix && vblank_seen_q;

  // Track line activity and frame start
  always_ff @(posedge clk) begin
    if (reset) begin
      line_act_q <= 1'b0;
      vblank_seen_q <= 1'b0;
    end else begin
      if (act_pix) begin
        line_act_q <= 1'b1;
      end else if (line_end) begin
        line_act_q <= 1'b0;
      end
      if (vid_in_valid && vid_ce_q && vid_in.vblank) begin
        vblank_seen_q <= 1'b1;
      end else if (new_frame) begin
        vblank_seen_q <= 1'b0;
      end
    end
  end

  // Store active pixels, blanking is dropped
  always_ff @(posedge clk) begin
    if (act_pix && wr_x_q < XW'(LINE_MAX)) begin
      line_mem[wr_bank_q][wr_x_q[XW-2:0]] <= vid_in.pixel;
    end
  end

  // Write column and bank swap at line end
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_x_q <= '0;
      wr_bank_q <= 1'b0;
      last_w_q <= '0;
      last_w_vld_q <= 1'b0;
    end else if (line_end) begin
      wr_x_q <= '0;
      wr_bank_q <= !wr_bank_q;
      last_w_q <= wr_x_q;
      last_w_vld_q <= !restart;
    end else if (act_pix && wr_x_q < XW'(LINE_MAX)) begin
      wr_x_q <= wr_x_q + 1'b1;
    end
  end

  // ****************************************************
  // Restart detection
  // ****************************************************
  // change detection
  assign change = (line_end && last_w_vld_q && wr_x_q != last_w_q)
                  || (cfg_live_q != cfg_prev_q
                      && deint_pkg::cfg_t'(cfg_sync) == cfg_prev_q);
  // Line finished before the last one was drained
  assign overrun = line_end && em_q != EM_IDLE;
  assign restart = change || overrun;

  // Error pulse for the outside
  always_ff @(posedge clk) begin
    if (reset) begin
      err_q <= 1'b0;
    end else begin
      err_q <= overrun;
    end
  end

  // ****************************************************
  // History counter
  // ****************************************************
  // history clear
  always_ff @(posedge clk) begin
    if (reset || restart) begin
      hist_q <= '0;
      armed_q <= 1'b0;
    end else if (new_frame) begin
      armed_q <= 1'b1;
      if (armed_q && hist_q < deint_pkg::HIST_FRAMES) begin
        hist_q <= hist_q + 1'b1;
      end
    end
  end

  // Per-frame kernel choice, taken at frame start
  // motion gate
  always_ff @(posedge clk) begin
    if (reset || restart) begin
      motion_q <= 1'b0;
    end else if (new_frame) begin
      motion_q <= cfg_live_q.enable && mem_ok && armed_q
                  && hist_q + 1'b1 >= deint_pkg::HIST_FRAMES;
    end
  end

  // Request a memory interface reset per restart
  // memory reset
  always_ff @(posedge clk) begin
    if (reset) begin
      restart_tgl_q <= 1'b0;
    end else if (restart) begin
      restart_tgl_q <= !restart_tgl_q;
    end
  end

  // ****************************************************
  // Memory domain
  // ****************************************************
  // request crossing
  level_sync #(.W(1)) u_mem_req_sync (
    .clk(mem_clk),
    .reset(!mem_reset_n),
    .d(restart_tgl_q),
    .q(mem_tgl_sync)
  );

  // Hold the memory interface in reset for a few cycles
  // memory reset
  always_ff @(posedge mem_clk) begin
    if (!mem_reset_n) begin
      mem_tgl_prev_q <= 1'b0;
      mem_rst_cnt_q <= deint_pkg::MEM_RST_CYCLES;
      mem_if_reset_q <= 1'b1;
      mem_ok_q <= 1'b0;
    end else begin
      mem_tgl_prev_q <= mem_tgl_sync;
      if (mem_tgl_sync != mem_tgl_prev_q) begin
        mem_rst_cnt_q <= deint_pkg::MEM_RST_CYCLES;
      end else if (mem_rst_cnt_q != 3'h0) begin
        mem_rst_cnt_q <= mem_rst_cnt_q - 1'b1;
      end
      mem_if_reset_q <= mem_rst_cnt_q != 3'h0
                        || mem_tgl_sync != mem_tgl_prev_q;
      mem_ok_q <= mem_history_ok && mem_rst_cnt_q == 3'h0;
    end
  end

  level_sync #(.W(1)) u_mem_ok_sync (
    .clk(clk),
    .reset(reset),
    .d(mem_ok_q),
    .q(mem_ok)
  );

  // ****************************************************
  // Output emitter
  // ****************************************************
  // Walk each stored line once or twice with own timing
  // progressive output
  always_ff @(posedge clk) begin
    if (reset) begin
      em_q <= EM_IDLE;
      rd_x_q <= '0;
      rd_len_q <= '0;
      rd_bank_q <= 1'b0;
      pass_q <= '0;
      passes_q <= '0;
      first_line_q <= 1'b0;
      em_fmotion_q <= 1'b0;
      em_fmt_q <= deint_pkg::CFG_RESET.fmt;
    end else begin
      if (new_frame) begin
        first_line_q <= 1'b1;
      end
      unique case (em_q)
        EM_IDLE: begin
          // Launch the line just finished
          if (line_end) begin
            rd_len_q <= wr_x_q;
            rd_bank_q <= wr_bank_q;
            rd_x_q <= '0;
            pass_q <= '0;
            passes_q <= cfg_live_q.enable ? deint_pkg::PASSES_DEINT
                                          : deint_pkg::PASSES_BYPASS;
            em_fmotion_q <= motion_q;
            em_fmt_q <= fmt;
            first_line_q <= 1'b0;
            em_q <= first_line_q ? EM_VBLANK : EM_PIXELS;
          end
        end
        EM_VBLANK: begin
          if (em_ready) begin
            em_q <= EM_PIXELS;
          end
        end
        EM_PIXELS: begin
          if (em_ready) begin
            if (rd_x_q + 1'b1 >= rd_len_q) begin
              em_q <= EM_HBLANK;
            end
            rd_x_q <= rd_x_q + 1'b1;
          end
        end
        EM_HBLANK: begin
          if (em_ready) begin
            rd_x_q <= '0;
            pass_q <= pass_q + 1'b1;
            em_q <= (pass_q + 1'b1 >= passes_q) ? EM_IDLE : EM_PIXELS;
          end
        end
      endcase
    end
  end

  always_comb begin
    em_data = '0;
    em_data.pixel = line_mem[rd_bank_q][rd_x_q[XW-2:0]];
    em_data.hblank = em_q == EM_HBLANK;
    em_data.vblank = em_q == EM_VBLANK;
    em_data.motion = em_fmotion_q;
    em_data.fmt = em_fmt_q;
  end

  assign em_valid = em_q != EM_IDLE;

  // Stall by the receiver loses no word
  // stream valid ready
  skid_buffer #(.W($bits(deint_pkg::vid_out_t))) u_out_buf (
    .clk(clk),
    .reset(reset),
    .s_valid(em_valid),
    .s_ready(em_ready),
    .s_data(em_data),
    .m_valid(vid_out_valid),
    .m_ready(vid_out_ready),
    .m_data(vid_out)
  );

  assign vid_ce = vid_ce_q;
  assign mem_if_reset = mem_if_reset_q;
  assign motion_active = motion_q;
  assign frame_error = err_q;

  // ****************************************************
  // Checks
  // ****************************************************
  property p_hist_clear;
    @(posedge clk) disable iff (reset)
    restart |=> hist_q == 2'h0 && !motion_q;
  endproperty
  a_hist_clear: assert property (p_hist_clear)
    else $error("history not cleared on restart");

  property p_motion_gate;
    @(posedge clk) disable iff (reset)
    $rose(motion_q) |-> hist_q == 2'h2 && $past(mem_ok);
  endproperty
  a_motion_gate: assert property (p_motion_gate)
    else $error("motion kernel without two fields");

  property p_first_frames;
    @(posedge clk) disable iff (reset)
    new_frame && !armed_q |=> !motion_q;
  endproperty
  a_first_frames: assert property (p_first_frames)
    else $error("motion used in first frame");

  property p_restore;
    @(posedge clk) disable iff (reset)
    new_frame && !restart && armed_q && hist_q == 2'h1
      && mem_ok && cfg_live_q.enable |=> motion_q;
  endproperty
  a_restore: assert property (p_restore)
    else $error("motion not restored after rebuild");

  property p_mem_req;
    @(posedge clk) disable iff (reset)
    restart |=> restart_tgl_q != $past(restart_tgl_q);
  endproperty
  a_mem_req: assert property (p_mem_req)
    else $error("memory reset not requested");

  property p_ce_half;
    @(posedge clk) disable iff (reset)
    vid_ce_q |=> !vid_ce_q ##1 vid_ce_q;
  endproperty
  a_ce_half: assert property (p_ce_half)
    else $error("clock enable not at half rate");

  property p_two_passes;
    @(posedge clk) disable iff (reset)
    em_q == EM_HBLANK && em_ready && pass_q == 2'h0
      && passes_q == deint_pkg::PASSES_DEINT |=> em_q == EM_PIXELS;
  endproperty
  a_two_passes: assert property (p_two_passes)
    else $error("line not emitted twice");

  property p_blank_pix;
    @(posedge clk) disable iff (reset)
    em_valid && !em_data.hblank && !em_data.vblank
      |-> em_q == EM_PIXELS && rd_x_q < rd_len_q;
  endproperty
  a_blank_pix: assert property (p_blank_pix)
    else $error("pixel emitted outside line");

  property p_fmt_static;
    @(posedge clk) disable iff (reset)
    !FMT_DYNAMIC |-> fmt == FMT_STATIC;
  endproperty
  a_fmt_static: assert property (p_fmt_static)
    else $error("static format overridden");

endmodule : deinterlace_history_sequencer

//--- rtl/deint_pkg.sv
package deint_pkg;

  // ****************************************************
  // Widths and counts
  // ****************************************************
  // Bits of one packed pixel
  localparam int PIX_W = 24;
  // Frames of history before the motion kernel may run
  localparam logic [1:0] HIST_FRAMES = 2'h2;
  // Cycles the memory interface reset is held
  localparam logic [2:0] MEM_RST_CYCLES = 3'h4;
  // Output passes of each stored line when deinterlacing
  localparam logic [1:0] PASSES_DEINT = 2'h2;
  // Output passes of each stored line in pass-through
  localparam logic [1:0] PASSES_BYPASS = 2'h1;

  // ****************************************************
  // Types
  // ****************************************************
  // Chroma sampling formats
  typedef enum logic [1:0] {FMT_420, FMT_422, FMT_444} chroma_fmt_t;

  // Input video beat
  typedef struct packed {
    logic [PIX_W-1:0] pixel;
    logic hblank;
    logic vblank;
  } vid_in_t;

  // Output video beat with synthetic timing
  typedef struct packed {
    logic [PIX_W-1:0] pixel;
    logic hblank;
    logic vblank;
    logic motion;
    chroma_fmt_t fmt;
  } vid_out_t;

  // Configuration word from the processor port
  typedef struct packed {
    logic enable;
    chroma_fmt_t fmt;
  } cfg_t;

  // Configuration reset value
  localparam cfg_t CFG_RESET = '{enable: 1'b0, fmt: FMT_422};

endpackage : deint_pkg

//--- rtl/level_sync.sv
`timescale 1ns/1ps

// ****************************************************
// Two flip-flop level synchroniser
// ****************************************************
module level_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // First stage, read only by the second
  logic [W-1:0] s1_q;
  // Second stage
  logic [W-1:0] s2_q;

  // Shift the level through both stages
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;

endmodule : level_sync

//--- rtl/skid_buffer.sv
`timescale 1ns/1ps

// ****************************************************
// Two-entry buffer, registered valid and ready
// ****************************************************
module skid_buffer #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [W-1:0] s_data,
  output logic m_valid,
  input wire logic m_ready,
  output logic [W-1:0] m_data
);

  // Head entry drives the output
  logic [W-1:0] head_q;
  // Tail entry catches a word during a stall
  logic [W-1:0] tail_q;
  logic head_vld_q;
  logic tail_vld_q;
  logic push;
  logic pop;

  assign push = s_valid && !tail_vld_q;
  assign pop = head_vld_q && m_ready;

  // Entry flags
  always_ff @(posedge clk) begin
    if (reset) begin
      head_vld_q <= 1'b0;
      tail_vld_q <= 1'b0;
    end else if (push && !pop) begin
      // Fill head first, then tail
      head_vld_q <= 1'b1;
      tail_vld_q <= head_vld_q;
    end else if (pop && !push) begin
      // Tail moves up or head empties
      head_vld_q <= tail_vld_q;
      tail_vld_q <= 1'b0;
    end
  end

  // Entry data
  always_ff @(posedge clk) begin
    if (push && (pop || !head_vld_q)) begin
      head_q <= s_data;
    end else if (pop && tail_vld_q) begin
      head_q <= tail_q;
    end
    if (push && head_vld_q && !pop) begin
      tail_q <= s_data;
    end
  end

  assign s_ready = !tail_vld_q;
  assign m_valid = head_vld_q;
  assign m_data = head_q;

endmodule : skid_buffer

//--- bench/mem_model.sv
`timescale 1ns/1ps

// ****************************************************
// Memory side model: history returns after a reset
// ****************************************************
module mem_model (
  input wire logic mem_clk,
  input wire logic mem_reset_n,
  input wire logic mem_if_reset,
  input wire logic block,
  output logic mem_history_ok
);
  // Memory cycles since the interface left reset
  int fill;

  initial begin
    mem_history_ok = 1'b0;
    fill = 0;
  end

  // Streams refill after any interface reset, stop when blocked
  // two reads fed
  always @(posedge mem_clk) begin
    #1;
    if (!mem_reset_n || mem_if_reset || block) begin
      fill = 0;
    end else if (fill < 3) begin
      fill = fill + 1;
    end
    mem_history_ok = (fill == 3);
  end
endmodule : mem_model

//--- bench/deinterlace_history_sequencer_tb.sv
`timescale 1ns/1ps

module deinterlace_history_sequencer_tb;
  // ****************************************************
  // Signals and model state
  // ****************************************************
  typedef struct packed {
    deint_pkg::vid_out_t v;
    logic pcare;
    logic mcare;
  } exp_t;
  logic clk = 1'b0;
  logic cfg_clk = 1'b0;
  logic mem_clk = 1'b0;
  logic reset, cfg_reset_n, mem_reset_n, vid_in_valid, vid_out_ready;
  logic block, rnd_ready, ready_hold, vid_ce, mem_history_ok;
  logic mem_if_reset, vid_out_valid, motion_active, frame_error;
  deint_pkg::vid_in_t vid_in;
  deint_pkg::cfg_t cfg;
  deint_pkg::vid_out_t vid_out;
  exp_t q[$];
  int num_errors = 0;
  int tests_run = 0;
  int hist = 0;
  int prev_w = 0;
  logic dc = 1'b0;
  logic mem_ok_m = 1'b1;
  logic skip = 1'b0;
  logic err_seen = 1'b0;
  logic memrst_seen = 1'b0;

  // unrelated clock rates; video clock 10 MHz
  always #50 clk = ~clk;
  always #65 cfg_clk = ~cfg_clk;
  // memory clock above 5 MHz * 5/4 / 0.70
  always #35 mem_clk = ~mem_clk;

  deinterlace_history_sequencer #(.LINE_MAX(16)) dut_u (
    .clk(clk), .reset(reset), .vid_in(vid_in),
    .vid_in_valid(vid_in_valid), .vid_ce(vid_ce), .cfg_clk(cfg_clk),
    .cfg_reset_n(cfg_reset_n), .general_processor_config_port(cfg),
    .mem_clk(mem_clk), .mem_reset_n(mem_reset_n),
    .mem_history_ok(mem_history_ok), .mem_if_reset(mem_if_reset),
    .vid_out(vid_out), .vid_out_valid(vid_out_valid),
    .vid_out_ready(vid_out_ready), .motion_active(motion_active),
    .frame_error(frame_error)
  );

  mem_model mem_u (
    .mem_clk(mem_clk), .mem_reset_n(mem_reset_n),
    .mem_if_reset(mem_if_reset), .block(block),
    .mem_history_ok(mem_history_ok)
  );

  // ****************************************************
  // Tasks
  // ****************************************************
  // Compare and count
  task check(input logic [23:0] seen, input logic [23:0] exp,
             input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // One input beat, presented for an enabled edge
  // throttled by enable
  task beat(input logic [23:0] p, input logic hb, input logic vb);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (vid_ce !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(24'(n < 4), 24'h1, "clock enable");
    if (n == 4) tally_and_finish();
    vid_in = '{pixel: p, hblank: hb, vblank: vb};
    vid_in_valid = 1'b1;
  endtask : beat

  // Send a frame and note the expected output words
  task send_frame(input int lines, input int w, input int gap);
    logic [23:0] px [16];
    exp_t e;
    logic mot;
    for (int l = 0; l < lines; l++) begin
      // blanking only marks the frame start
      if (l == 0) beat(24'h0, 1'b0, 1'b1);
      for (int i = 0; i < w; i++) begin
        px[i] = 24'($urandom);
        beat(px[i], 1'b0, 1'b0);
        if (l == 0 && i == 0) begin
          dc = 1'b0;
          hist = (hist < 3) ? hist + 1 : 3;
        end
      end
      beat(24'h0, 1'b1, 1'b0);
      if (prev_w != 0 && w != prev_w) begin
        hist = 0;
        dc = 1'b1;
      end
      prev_w = w;
      mot = cfg.enable && hist >= 3 && mem_ok_m;
      if (l == 0 && !dc) check(24'(motion_active), 24'(mot), "flag");
      e = '{v: '{pixel: 24'h0, hblank: 1'b0, vblank: 1'b1, motion: mot,
               fmt: cfg.fmt}, pcare: 1'b0, mcare: !dc};
      if (l == 0) q.push_back(e);
      e.v.vblank = 1'b0;
      for (int r = 0; r < (cfg.enable ? 2 : 1); r++) begin
        e.pcare = 1'b1;
        for (int i = 0; i < w; i++) begin
          e.v.pixel = px[i];
          q.push_back(e);
        end
        e.pcare = 1'b0;
        e.v.hblank = 1'b1;
        q.push_back(e);
        e.v.hblank = 1'b0;
      end
      for (int g = 0; g < gap; g++) beat(24'h0, 1'b1, 1'b0);
    end
    @(posedge clk);
    #1;
    vid_in_valid = 1'b0;
  endtask : send_frame

  task set_cfg(input logic en, input deint_pkg::chroma_fmt_t f);
    @(posedge cfg_clk);
    #1;
    cfg = '{enable: en, fmt: f};
    hist = 0;
    repeat (20) @(posedge clk);
  endtask : set_cfg

  // Wait for every noted word, bounded
  task drain(input string name);
    int n;
    n = 0;
    while (q.size() != 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check(24'(q.size()), 24'h0, "words missing");
    if (q.size() != 0) tally_and_finish();
    check(24'(err_seen), 24'h0, "error pulse");
    $display("test %s done", name);
  endtask : drain

  // ****************************************************
  // Watchers
  // ****************************************************
  // Output words taken at the coming edge are compared
  always @(negedge clk) begin : watch
    exp_t e;
    if (frame_error === 1'b1) err_seen = 1'b1;
    if (vid_out_valid === 1'b1 && vid_out_ready === 1'b1 && !skip) begin
      if (q.size() == 0) begin
        check(24'h1, 24'h0, "unexpected word");
      end else begin
        e = q.pop_front();
        if (e.pcare) check(vid_out.pixel, e.v.pixel, "pixel");
        check(24'(vid_out.hblank), 24'(e.v.hblank), "hblank");
        check(24'(vid_out.vblank), 24'(e.v.vblank), "vblank");
        check(24'(vid_out.fmt), 24'(e.v.fmt), "format");
        if (e.mcare) begin
          check(24'(vid_out.motion), 24'(e.v.motion), "motion");
        end
      end
    end
  end

  // Memory interface reset seen
  always @(posedge mem_clk) begin
    if (mem_if_reset === 1'b1) memrst_seen = 1'b1;
  end

  always @(posedge clk) begin
    #1;
    vid_out_ready = rnd_ready ? ($urandom % 4 != 0) : ready_hold;
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    // video reset high; other resets low
    reset = 1'b1;
    cfg_reset_n = 1'b0;
    mem_reset_n = 1'b0;
    vid_in_valid = 1'b0;
    vid_in = '0;
    vid_out_ready = 1'b1;
    rnd_ready = 1'b0;
    ready_hold = 1'b1;
    block = 1'b0;
    cfg = deint_pkg::CFG_RESET;
    void'($urandom(37122));
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    cfg_reset_n = 1'b1;
    mem_reset_n = 1'b1;
    set_cfg(1'b1, deint_pkg::FMT_422);
    repeat (4) send_frame(2, 4, 3);
    drain("startup");
    // history rebuilt after an input change
    memrst_seen = 1'b0;
    repeat (4) send_frame(2, 3, 3);
    drain("input change");
    check(24'(memrst_seen), 24'h1, "memory reset");
    block = 1'b1;
    mem_ok_m = 1'b0;
    repeat (20) @(posedge clk);
    repeat (3) send_frame(2, 3, 3);
    drain("history blocked");
    block = 1'b0;
    mem_ok_m = 1'b1;
    // formats chosen at run time, pass-through
    for (int f = 0; f < 3; f++) begin
      set_cfg(1'b0, deint_pkg::chroma_fmt_t'(f));
      send_frame(2, 3, 3);
      drain("format");
    end
    set_cfg(1'b1, deint_pkg::FMT_444);
    rnd_ready = 1'b1;
    repeat (3) send_frame(3, 4, 10);
    drain("random stall");
    rnd_ready = 1'b0;
    // Stalled output forces a line overrun
    ready_hold = 1'b0;
    skip = 1'b1;
    send_frame(3, 4, 0);
    repeat (20) @(posedge clk);
    check(24'(err_seen), 24'h1, "overrun pulse");
    $display("test overrun done");
    tally_and_finish();
  end
endmodule : deinterlace_history_sequencer_tb
